//--- core/msm_monitor.v
// switch input monitor: filtered comparator states, adc results, polling, interrupt
// assumes an analog front end that presents comparator and adc data, stable
// around each rising edge of sample_clk_in, and an avalon-mm master on sys_clk_in
// Contract
// - each of 24 inputs has a comparator threshold select of four levels.
// - threshold select resets to the 2.0 V level.
// - no sampling until the trigger bit is set; host sets it after setup.
// - per input, rising, falling or both edges may raise an event.
// - a change is valid only after persisting the configured sample count.
// - a filtered change on an enabled selected input drives the interrupt low.
// - interrupt is open drain; its falling edge comes from a change event.
// - every read returns status flags, including the switch change flag.
// - comparator status bit n shows the state of input n.
// - per-input wetting current select, one setting gives 1 mA.
// - analog inputs sample with zero wetting current.
// - analog inputs store a 10-bit result after every sample; each sample stores only the channel on adc_chan_in, if enabled.
// - adc results are readable any time, giving the latest sample.
// - an analog value crossing the programmed threshold raises an interrupt.
// - polling mode samples only in an active window of each period.
`include "msm_map.vh"
module msm_monitor (
    input  wire        sys_clk_in,
    input  wire        rst_in,
    input  wire [7:0]  avs_address_in,
    input  wire        avs_read_in,
    input  wire        avs_write_in,
    input  wire [31:0] avs_writedata_in,
    output reg  [31:0] avs_readdata_out,
    output reg         avs_waitrequest_out,
    input  wire        sample_clk_in,
    input  wire [23:0] comp_in,
    input  wire [9:0]  adc_data_in,
    input  wire [4:0]  adc_chan_in,
    output reg  [47:0] thr_sel_out,
    output reg  [47:0] wet_sel_out,
    output reg  [23:0] in_en_out,
    output reg  [23:0] ana_mode_out,
    output reg         poll_active_out,
    input  wire        irq_n_in,
    output reg         irq_n_out,
    output reg         irq_oe_out,
    output reg         irq_out
);
    localparam integer TICK_LAST_I = `MSM_TICK_CYC - 1;
    localparam integer NUM_IN_I    = `MSM_NUM_IN;
    localparam [5:0]   TICK_LAST   = TICK_LAST_I[5:0];
    localparam [4:0]   NUM_IN      = NUM_IN_I[4:0];

    reg [31:0] cfg_reg;
    reg [23:0] in_en_reg;
    reg [23:0] rise_en_reg;
    reg [23:0] fall_en_reg;
    reg [47:0] thr_reg;
    reg [47:0] wet_reg;
    reg [23:0] ana_mode_reg;
    reg [23:0] comp_stat_reg;
    reg [23:0] evt_stat_reg;
    reg [1:0]  irq_stat_reg;
    reg [1:0]  irq_mask_reg;
    reg [9:0]  ana_thr_reg;
    reg [15:0] poll_time_reg;
    reg [15:0] poll_act_reg;
    reg [15:0] poll_cnt_reg;
    reg [5:0]  tick_cnt_reg;
    reg [23:0] ana_above_reg;
    reg [23:0] ana_seen_reg;
    reg [3:0]  filt_cnt_reg [0:23];
    reg [9:0]  adc_res_reg  [0:23];
    // two-stage synchronisers, third stage only for the sample clock edge
    reg        samp_s1_reg;
    reg        samp_s2_reg;
    reg        samp_s3_reg;
    reg [23:0] comp_s1_reg;
    reg [23:0] comp_s2_reg;
    reg [9:0]  adc_s1_reg;
    reg [9:0]  adc_s2_reg;
    reg [4:0]  chan_s1_reg;
    reg [4:0]  chan_s2_reg;
    reg        pin_s1_reg;
    reg        pin_s2_reg;

    reg [23:0] reach;
    reg [23:0] sw_set;
    reg [23:0] evt_clr;
    reg [1:0]  irq_set;
    reg [1:0]  irq_clr;
    reg [31:0] rd_val;
    reg        ana_hit;
    reg        ch_ok;
    reg        above_now;
    reg [3:0]  filt_eff;
    integer    i;
    integer    j;

    wire       fire     = (avs_read_in | avs_write_in) & avs_waitrequest_out;
    wire       wr_fire  = fire & avs_write_in;
    wire       rd_fire  = fire & avs_read_in;
    wire       samp_edge = samp_s2_reg & ~samp_s3_reg;
    wire       trig     = cfg_reg[`MSM_CFG_TRIG];
    wire       poll_en  = cfg_reg[`MSM_CFG_POLL];
    wire       poll_win = poll_cnt_reg < poll_act_reg;
    wire       us_tick  = tick_cnt_reg == TICK_LAST;
    // polling gates samples to the active window
    wire       sample_ok = samp_edge & trig & (~poll_en | poll_win);
    wire       is_adc   = (avs_address_in >= `MSM_OFF_ADC_BASE) &&
                          (avs_address_in <= `MSM_OFF_ADC_LAST) &&
                          (avs_address_in[1:0] == 2'h0);
    wire [7:0] adc_off  = avs_address_in - `MSM_OFF_ADC_BASE;
    wire [4:0] adc_idx  = adc_off[6:2];
    wire [1:0] irq_act  = irq_stat_reg & irq_mask_reg;

    // sticky flag update where a set in the same cycle beats the clear
    function [23:0] sticky;
        input [23:0] cur;
        input [23:0] set;
        input [23:0] clr;
        begin
            sticky = set | (cur & ~clr);
        end
    endfunction

    // channel lookup that reads zero past the last input
    function pick;
        input [23:0] vec;
        input [4:0]  idx;
        begin
            pick = (idx < NUM_IN) ? vec[idx] : 1'b0;
        end
    endfunction

    always @*
    begin
        filt_eff = cfg_reg[`MSM_CFG_FILT_HI:`MSM_CFG_FILT_LO];
        if (filt_eff == 4'h0)
        begin
            filt_eff = 4'h1;
        end
        for (i = 0; i < `MSM_NUM_IN; i = i + 1)
        begin
            // change counts only while it persists
            reach[i] = in_en_reg[i] & ~ana_mode_reg[i] &
                       (comp_s2_reg[i] != comp_stat_reg[i]) &
                       (({1'b0, filt_cnt_reg[i]} + 5'h01) >= {1'b0, filt_eff});
        end
        sw_set = {24{sample_ok}} & reach &
                 ((comp_s2_reg & rise_en_reg) | (~comp_s2_reg & fall_en_reg));
        ch_ok = pick(ana_mode_reg, chan_s2_reg) &
                pick(in_en_reg, chan_s2_reg);
        above_now = adc_s2_reg >= ana_thr_reg;
        ana_hit = sample_ok & ch_ok & pick(ana_seen_reg, chan_s2_reg) &
                  (above_now != pick(ana_above_reg, chan_s2_reg));
        irq_set = {ana_hit, |sw_set};
        irq_clr = 2'h0;
        evt_clr = 24'h00_0000;
        if (wr_fire && avs_address_in == `MSM_OFF_EVT_STAT)
        begin
            evt_clr = avs_writedata_in[23:0];
        end
        if (wr_fire && avs_address_in == `MSM_OFF_IRQ_STAT)
        begin
            irq_clr = avs_writedata_in[1:0];
        end
        // reading the interrupt status clears flags and events
        if (rd_fire && avs_address_in == `MSM_OFF_IRQ_STAT)
        begin
            irq_clr = 2'h3;
            evt_clr = 24'hFF_FFFF;
        end
        rd_val = 32'h0000_0000;
        if (avs_address_in == `MSM_OFF_CONFIG)
            rd_val = {24'h00_0000, cfg_reg[7:0]};
        else if (avs_address_in == `MSM_OFF_IN_EN)
            rd_val = {8'h00, in_en_reg};
        else if (avs_address_in == `MSM_OFF_EDGE_RISE)
            rd_val = {8'h00, rise_en_reg};
        else if (avs_address_in == `MSM_OFF_EDGE_FALL)
            rd_val = {8'h00, fall_en_reg};
        else if (avs_address_in == `MSM_OFF_THR_A)
            rd_val = {8'h00, thr_reg[23:0]};
        else if (avs_address_in == `MSM_OFF_THR_B)
            rd_val = {8'h00, thr_reg[47:24]};
        else if (avs_address_in == `MSM_OFF_WET_A)
            rd_val = {8'h00, wet_reg[23:0]};
        else if (avs_address_in == `MSM_OFF_WET_B)
            rd_val = {8'h00, wet_reg[47:24]};
        else if (avs_address_in == `MSM_OFF_ANA_MODE)
            rd_val = {8'h00, ana_mode_reg};
        else if (avs_address_in == `MSM_OFF_COMP_STAT)
            rd_val = {8'h00, comp_stat_reg};
        else if (avs_address_in == `MSM_OFF_EVT_STAT)
            rd_val = {8'h00, evt_stat_reg};
        else if (avs_address_in == `MSM_OFF_IRQ_STAT)
            rd_val = {23'h00_0000, pin_s2_reg, 6'h00, irq_stat_reg};
        else if (avs_address_in == `MSM_OFF_IRQ_MASK)
            rd_val = {30'h0000_0000, irq_mask_reg};
        else if (avs_address_in == `MSM_OFF_ANA_THR)
            rd_val = {22'h00_0000, ana_thr_reg};
        else if (avs_address_in == `MSM_OFF_POLL_TIME)
            rd_val = {16'h0000, poll_time_reg};
        else if (avs_address_in == `MSM_OFF_POLL_ACT)
            rd_val = {16'h0000, poll_act_reg};
        // latest result readable at any time
        else if (is_adc)
            rd_val = {22'h00_0000, adc_res_reg[adc_idx]};
        rd_val[`MSM_FLAG_POS+1:`MSM_FLAG_POS] = irq_stat_reg;
    end

    always @(posedge sys_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            cfg_reg       <= {24'h00_0000, `MSM_FILT_RST, 4'h0};
            in_en_reg     <= 24'h00_0000;
            rise_en_reg   <= 24'h00_0000;
            fall_en_reg   <= 24'h00_0000;
            // all thresholds start at 2.0 V
            thr_reg       <= {24{`MSM_THR_2V0}};
            wet_reg       <= {24{`MSM_WET_0MA}};
            ana_mode_reg  <= 24'h00_0000;
            comp_stat_reg <= 24'h00_0000;
            evt_stat_reg  <= 24'h00_0000;
            irq_stat_reg  <= 2'h0;
            irq_mask_reg  <= 2'h0;
            ana_thr_reg   <= `MSM_ANA_THR_RST;
            poll_time_reg <= `MSM_POLL_TIME_RST;
            poll_act_reg  <= `MSM_POLL_ACT_RST;
            poll_cnt_reg  <= 16'h0000;
            tick_cnt_reg  <= 6'h00;
            ana_above_reg <= 24'h00_0000;
            ana_seen_reg  <= 24'h00_0000;
            for (j = 0; j < `MSM_NUM_IN; j = j + 1)
            begin
                filt_cnt_reg[j] <= 4'h0;
                adc_res_reg[j]  <= 10'h000;
            end
            samp_s1_reg <= 1'b0;
            samp_s2_reg <= 1'b0;
            samp_s3_reg <= 1'b0;
            comp_s1_reg <= 24'h00_0000;
            comp_s2_reg <= 24'h00_0000;
            adc_s1_reg  <= 10'h000;
            adc_s2_reg  <= 10'h000;
            chan_s1_reg <= 5'h00;
            chan_s2_reg <= 5'h00;
            pin_s1_reg  <= 1'b1;
            pin_s2_reg  <= 1'b1;
            avs_readdata_out    <= 32'h0000_0000;
            avs_waitrequest_out <= 1'b1;
            thr_sel_out     <= {24{`MSM_THR_2V0}};
            wet_sel_out     <= {24{`MSM_WET_0MA}};
            in_en_out       <= 24'h00_0000;
            ana_mode_out    <= 24'h00_0000;
            poll_active_out <= 1'b0;
            irq_n_out       <= 1'b0;
            irq_oe_out      <= 1'b0;
            irq_out         <= 1'b0;
        end
        else
        begin
            samp_s1_reg <= sample_clk_in;
            samp_s2_reg <= samp_s1_reg;
            samp_s3_reg <= samp_s2_reg;
            comp_s1_reg <= comp_in;
            comp_s2_reg <= comp_s1_reg;
            adc_s1_reg  <= adc_data_in;
            adc_s2_reg  <= adc_s1_reg;
            chan_s1_reg <= adc_chan_in;
            chan_s2_reg <= chan_s1_reg;
            pin_s1_reg  <= irq_n_in;
            pin_s2_reg  <= pin_s1_reg;

            // one wait cycle, then a single acknowledge cycle
            avs_waitrequest_out <= ~fire;
            if (rd_fire)
            begin
                avs_readdata_out <= rd_val;
            end
            if (wr_fire)
            begin
                if (avs_address_in == `MSM_OFF_CONFIG)
                    cfg_reg <= {24'h00_0000, avs_writedata_in[7:4], 2'h0,
                                avs_writedata_in[1:0]};
                else if (avs_address_in == `MSM_OFF_IN_EN)
                    in_en_reg <= avs_writedata_in[23:0];
                else if (avs_address_in == `MSM_OFF_EDGE_RISE)
                    rise_en_reg <= avs_writedata_in[23:0];
                else if (avs_address_in == `MSM_OFF_EDGE_FALL)
                    fall_en_reg <= avs_writedata_in[23:0];
                else if (avs_address_in == `MSM_OFF_THR_A)
                    thr_reg[23:0] <= avs_writedata_in[23:0];
                else if (avs_address_in == `MSM_OFF_THR_B)
                    thr_reg[47:24] <= avs_writedata_in[23:0];
                else if (avs_address_in == `MSM_OFF_WET_A)
                    wet_reg[23:0] <= avs_writedata_in[23:0];
                else if (avs_address_in == `MSM_OFF_WET_B)
                    wet_reg[47:24] <= avs_writedata_in[23:0];
                else if (avs_address_in == `MSM_OFF_ANA_MODE)
                    ana_mode_reg <= avs_writedata_in[23:0];
                else if (avs_address_in == `MSM_OFF_IRQ_MASK)
                    irq_mask_reg <= avs_writedata_in[1:0];
                else if (avs_address_in == `MSM_OFF_ANA_THR)
                    ana_thr_reg <= avs_writedata_in[9:0];
                else if (avs_address_in == `MSM_OFF_POLL_TIME)
                    poll_time_reg <= avs_writedata_in[15:0];
                else if (avs_address_in == `MSM_OFF_POLL_ACT)
                    poll_act_reg <= avs_writedata_in[15:0];
            end

            evt_stat_reg <= sticky(evt_stat_reg, sw_set, evt_clr);
            irq_stat_reg <= irq_set | (irq_stat_reg & ~irq_clr);

            // period and active window in microsecond ticks
            tick_cnt_reg <= us_tick ? 6'h00 : tick_cnt_reg + 6'h01;
            if (!trig || !poll_en)
                poll_cnt_reg <= 16'h0000;
            else if (us_tick)
                poll_cnt_reg <= (poll_cnt_reg + 16'h0001 >= poll_time_reg) ?
                                16'h0000 : poll_cnt_reg + 16'h0001;

            if (sample_ok)
            begin
                for (j = 0; j < `MSM_NUM_IN; j = j + 1)
                begin
                    // commit after persisting, restart count on bounce
                    if (reach[j])
                    begin
                        comp_stat_reg[j] <= comp_s2_reg[j];
                        filt_cnt_reg[j]  <= 4'h0;
                    end
                    else if (in_en_reg[j] && !ana_mode_reg[j] &&
                             comp_s2_reg[j] != comp_stat_reg[j])
                        filt_cnt_reg[j] <= filt_cnt_reg[j] + 4'h1;
                    else
                        filt_cnt_reg[j] <= 4'h0;
                    if (ana_mode_reg[j])
                        comp_stat_reg[j] <= 1'b0;
                end
                // store result of the converted channel
                if (ch_ok)
                begin
                    adc_res_reg[chan_s2_reg]   <= adc_s2_reg;
                    ana_above_reg[chan_s2_reg] <= above_now;
                    ana_seen_reg[chan_s2_reg]  <= 1'b1;
                end
            end

            thr_sel_out  <= thr_reg;
            in_en_out    <= in_en_reg;
            ana_mode_out <= ana_mode_reg;
            for (j = 0; j < `MSM_NUM_IN; j = j + 1)
            begin
                // analog inputs get no wetting current
                wet_sel_out[2*j +: 2] <= ana_mode_reg[j] ? `MSM_WET_0MA : wet_reg[2*j +: 2];
            end
            poll_active_out <= trig & (~poll_en | poll_win);
            // unmasked event pulls the line low
            // open drain, only ever driven low
            irq_n_out  <= 1'b0;
            irq_oe_out <= |irq_act;
            irq_out    <= |irq_act;
        end
    end
endmodule // msm_monitor

//--- core/msm_map.vh
// offsets, field positions, reset values and timing counts of the monitor
// assumes inclusion by msm_monitor.v and the test bench; byte addresses on a 32-bit bus
`ifndef MSM_MAP_VH
`define MSM_MAP_VH
`define MSM_NUM_IN         24
`define MSM_OFF_CONFIG     8'h00
`define MSM_OFF_IN_EN      8'h04
`define MSM_OFF_EDGE_RISE  8'h08
`define MSM_OFF_EDGE_FALL  8'h0C
`define MSM_OFF_THR_A      8'h10
`define MSM_OFF_THR_B      8'h14
`define MSM_OFF_WET_A      8'h18
`define MSM_OFF_WET_B      8'h1C
`define MSM_OFF_ANA_MODE   8'h20
`define MSM_OFF_COMP_STAT  8'h24
`define MSM_OFF_EVT_STAT   8'h28
`define MSM_OFF_IRQ_STAT   8'h2C
`define MSM_OFF_IRQ_MASK   8'h30
`define MSM_OFF_ANA_THR    8'h34
`define MSM_OFF_POLL_TIME  8'h38
`define MSM_OFF_POLL_ACT   8'h3C
`define MSM_OFF_ADC_BASE   8'h40
`define MSM_OFF_ADC_LAST   8'h9C
`define MSM_CFG_TRIG       0
`define MSM_CFG_POLL       1
`define MSM_CFG_FILT_LO    4
`define MSM_CFG_FILT_HI    7
`define MSM_IRQ_SWITCH     0
`define MSM_IRQ_ANALOG     1
`define MSM_IRQ_PIN        8
`define MSM_FLAG_POS       30
`define MSM_FILT_RST       4'h3
`define MSM_THR_2V0        2'h0
`define MSM_THR_2V7        2'h1
`define MSM_THR_3V0        2'h2
`define MSM_THR_4V0        2'h3
`define MSM_WET_0MA        2'h0
`define MSM_WET_1MA        2'h1
`define MSM_ANA_THR_RST    10'h200
`define MSM_POLL_TIME_RST  16'hFA00
`define MSM_POLL_ACT_RST   16'h0040
`define MSM_CLK_HZ         50000000
`define MSM_TICK_US        1
`define MSM_TICK_CYC       ((`MSM_CLK_HZ / 1000000) * `MSM_TICK_US)
`endif

//--- dv/msm_check_monitor.sv
// checker: bus, interrupt and setup properties of the monitor
// assumes binding to the ports of msm_monitor
module msm_check_monitor (
    input wire logic        sys_clk_in,
    input wire logic        rst_in,
    input wire logic [7:0]  avs_address_in,
    input wire logic        avs_read_in,
    input wire logic        avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [31:0] avs_readdata_out,
    input wire logic        avs_waitrequest_out,
    input wire logic [47:0] thr_sel_out,
    input wire logic [47:0] wet_sel_out,
    input wire logic [23:0] ana_mode_out,
    input wire logic        poll_active_out,
    input wire logic        irq_n_out,
    input wire logic        irq_oe_out,
    input wire logic        irq_out
);
    logic        take;
    logic        rd_take;
    logic        trig_seen;
    logic [47:0] ana2;
    assign take = (avs_read_in | avs_write_in) & avs_waitrequest_out;
    assign rd_take = take & avs_read_in;
    always_comb
        for (int i = 0; i < 24; i++)
            ana2[2*i +: 2] = {2{ana_mode_out[i]}};
    // set once a trigger write is taken
    always_ff @(posedge sys_clk_in or posedge rst_in)
        if (rst_in)
            trig_seen <= 1'b0;
        else if (take & avs_write_in & (avs_address_in == 8'h00) & avs_writedata_in[0])
            trig_seen <= 1'b1;
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (rst_in);
    wait_one_a: assert property (take |=> !avs_waitrequest_out)
        else $error("no answer one cycle after request");
    wait_short_a: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
        else $error("waitrequest low too long");
    thr_reset_a: assert property ($fell(rst_in) |-> thr_sel_out == 48'h0)
        else $error("threshold select not at default");
    wet_analog_a: assert property ((wet_sel_out & ana2) == 48'h0)
        else $error("current on analog input");
    no_trigger_a: assert property (!trig_seen |-> !poll_active_out)
        else $error("sampling before trigger");
    pin_low_a: assert property (irq_n_out == 1'b0)
        else $error("pin driven high");
    oe_match_a: assert property (irq_oe_out == irq_out)
        else $error("pin enable differs from interrupt");
    irq_hold_a: assert property (irq_out && !take && !$past(take) |=> irq_out)
        else $error("interrupt dropped without access");
    read_flags_a: assert property (rd_take && avs_address_in == 8'h2C
        |=> avs_readdata_out[31:30] == avs_readdata_out[1:0])
        else $error("status flags differ");
    adc_width_a: assert property (
        rd_take && avs_address_in >= 8'h40 && avs_address_in <= 8'h9C
        |=> avs_readdata_out[29:10] == 20'h0)
        else $error("adc result wider than ten bits");
    unmapped_zero_a: assert property (rd_take && avs_address_in > 8'h9C
        |=> avs_readdata_out[29:0] == 30'h0)
        else $error("unmapped read not zero");
    irq_rise_c: cover property ($rose(irq_out));
    poll_rise_c: cover property ($rose(poll_active_out));
    adc_read_c: cover property (rd_take && avs_address_in == 8'h40);
endmodule // msm_check_monitor
bind msm_monitor msm_check_monitor u_chk (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
    .avs_writedata_in(avs_writedata_in), .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out), .thr_sel_out(thr_sel_out),
    .wet_sel_out(wet_sel_out), .ana_mode_out(ana_mode_out), .poll_active_out(poll_active_out),
    .irq_n_out(irq_n_out), .irq_oe_out(irq_oe_out), .irq_out(irq_out));

//--- dv/msm_front_model.sv
// front end model: sample clock bursts, comparator and adc data, pulled-up pin
// assumes the bench calls burst between checks; data only change while the clock is low
module msm_front_model (
    input  wire logic        irq_oe_in,
    input  wire logic        irq_drv_in,
    output logic             sample_clk_out,
    output logic [23:0]      comp_out,
    output logic [9:0]       adc_out,
    output logic [4:0]       chan_out,
    output wire logic        irq_pin_out
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        sample_clk_out = 1'b0;
        comp_out = 24'h00_0000;
        adc_out = 10'h000;
        chan_out = 5'h1F;
    end
    // open-drain pin with pull-up
    assign irq_pin_out = irq_oe_in ? irq_drv_in : 1'b1;
    task automatic burst(input int n, input logic [23:0] c, input logic [9:0] d,
                         input logic [4:0] ch);
        comp_out <= c;
        adc_out <= d;
        chan_out <= ch;
        #80;
        repeat (n)
        begin
            sample_clk_out <= 1'b1;
            #80;
            sample_clk_out <= 1'b0;
            #80;
        end
        #80;
    endtask
endmodule // msm_front_model

//--- dv/multi_switch_input_monitor_test.sv
// self-checking bench for the switch input monitor
// assumes msm_monitor, the front model and the bound checker are compiled
`include "msm_map.vh"
module multi_switch_input_monitor_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic        sys_clk_in = 1'b0;
    logic        rst_in = 1'b1;
    logic        rd = 1'b0;
    logic        wr = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic [31:0] rdata, q;
    logic        wrq, irq_n, irq_oe, irq, poll, sclk, pin;
    logic        host_supply_hold = 1'b0;
    logic [47:0] thr, wet;
    logic [23:0] en, ana, comp, v, cexp;
    logic [9:0]  adc;
    logic [4:0]  chan;
    int          miscompares = 0;
    int          compares = 0;
    int          hi;
    int          seed = 32'h54b1_bb63;
    always #10 sys_clk_in = ~sys_clk_in;
    msm_monitor u_dut (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .avs_address_in(addr),
        .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata),
        .avs_readdata_out(rdata), .avs_waitrequest_out(wrq), .sample_clk_in(sclk),
        .comp_in(comp), .adc_data_in(adc), .adc_chan_in(chan), .thr_sel_out(thr),
        .wet_sel_out(wet), .in_en_out(en), .ana_mode_out(ana), .poll_active_out(poll),
        .irq_n_in(pin), .irq_n_out(irq_n), .irq_oe_out(irq_oe), .irq_out(irq));
    msm_front_model u_fe (.irq_oe_in(irq_oe), .irq_drv_in(irq_n), .sample_clk_out(sclk),
        .comp_out(comp), .adc_out(adc), .chan_out(chan), .irq_pin_out(pin));
    task automatic tally_and_finish;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            miscompares++;
            $display("FAIL t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // expected status word: flags in 31:30, pin level in bit 8
    function automatic logic [31:0] stat_word(logic sw, logic an, logic p);
        return {an, sw, 21'h0, p, 6'h0, an, sw};
    endfunction
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge sys_clk_in);
        rd <= !w;
        wr <= w;
        addr <= a;
        wdata <= d;
        @(posedge sys_clk_in);
        while (wrq !== 1'b0 && n < 50)
        begin
            @(posedge sys_clk_in);
            n++;
        end
        if (n >= 50)
        begin
            miscompares++;
            tally_and_finish;
        end
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk({2'b00, q[29:0]}, e);
    endtask
    task automatic settle;
        repeat (2) @(posedge sys_clk_in);
        #1;
    endtask
    initial
    begin
        #(20 * 20000);
        miscompares++;
        tally_and_finish;
    end
    initial
    begin
        repeat (16) @(posedge sys_clk_in);
        rst_in <= 1'b0;
        rchk(`MSM_OFF_CONFIG, 32'h0000_0030);
        rchk(`MSM_OFF_THR_A, 32'h0000_0000);
        rchk(`MSM_OFF_ANA_THR, 32'h0000_0200);
        rchk(`MSM_OFF_POLL_TIME, 32'h0000_FA00);
        rchk(`MSM_OFF_POLL_ACT, 32'h0000_0040);
        rchk(8'hA0, 32'h0000_0000);
        $display("test defaults done");
        for (int lv = 0; lv < 4; lv++)
        begin
            bus(1'b1, `MSM_OFF_THR_A, {8'h00, {12{lv[1:0]}}});
            settle;
            chk({8'h00, thr[23:0]}, {8'h00, {12{lv[1:0]}}});
        end
        bus(1'b1, `MSM_OFF_THR_A, 32'h0);
        bus(1'b1, `MSM_OFF_WET_A, 32'h0000_0001);
        settle;
        chk({30'h0, wet[1:0]}, 32'h0000_0001);
        bus(1'b1, `MSM_OFF_ANA_MODE, 32'h0000_0001);
        settle;
        chk({30'h0, wet[1:0]}, 32'h0000_0000);
        chk({8'h00, ana}, 32'h0000_0001);
        $display("test select outputs done");
        bus(1'b1, `MSM_OFF_IN_EN, 32'h0000_000D);
        bus(1'b1, `MSM_OFF_EDGE_RISE, 32'h0000_000C);
        bus(1'b1, `MSM_OFF_EDGE_FALL, 32'h0000_000C);
        bus(1'b1, `MSM_OFF_IRQ_MASK, 32'h0000_0003);
        u_fe.burst(4, 24'h00_000C, 10'h0, 5'h1F);
        rchk(`MSM_OFF_COMP_STAT, 32'h0000_0000);
        chk({8'h00, en}, 32'h0000_000D);
        chk({31'h0, irq}, 32'h0);
        bus(1'b1, `MSM_OFF_CONFIG, 32'h0000_0031);
        u_fe.burst(2, 24'h00_000C, 10'h0, 5'h1F);
        rchk(`MSM_OFF_COMP_STAT, 32'h0000_0000);
        u_fe.burst(1, 24'h00_000C, 10'h0, 5'h1F);
        rchk(`MSM_OFF_COMP_STAT, 32'h0000_000C);
        chk({31'h0, irq}, 32'h1);
        chk({31'h0, pin}, 32'h0);
        host_supply_hold <= 1'b1;
        bus(1'b0, `MSM_OFF_IRQ_STAT, 32'h0);
        chk(q, stat_word(1'b1, 1'b0, 1'b0));
        rchk(`MSM_OFF_EVT_STAT, 32'h0000_0000);
        settle;
        chk({31'h0, irq}, 32'h0);
        host_supply_hold <= 1'b0;
        bus(1'b1, `MSM_OFF_EDGE_FALL, 32'h0);
        u_fe.burst(3, 24'h00_0000, 10'h0, 5'h1F);
        rchk(`MSM_OFF_EVT_STAT, 32'h0000_0000);
        bus(1'b1, `MSM_OFF_EDGE_RISE, 32'h0000_0004);
        u_fe.burst(3, 24'h00_000C, 10'h0, 5'h1F);
        rchk(`MSM_OFF_EVT_STAT, 32'h0000_0004);
        bus(1'b1, `MSM_OFF_EVT_STAT, 32'h0000_0004);
        rchk(`MSM_OFF_EVT_STAT, 32'h0000_0000);
        bus(1'b1, `MSM_OFF_COMP_STAT, 32'h00FF_FFFF);
        rchk(`MSM_OFF_COMP_STAT, 32'h0000_000C);
        $display("test filter and edges done");
        cexp = 24'h00_000C;
        repeat (4)
        begin
            hi = $random(seed);
            v = $random(seed);
            bus(1'b1, `MSM_OFF_IN_EN, {8'h00, hi[23:0]});
            u_fe.burst(3, v, 10'h0, 5'h1F);
            cexp = ((v & hi[23:0]) | (cexp & ~hi[23:0])) & 24'hFF_FFFE;
            rchk(`MSM_OFF_COMP_STAT, {8'h00, cexp});
        end
        bus(1'b1, `MSM_OFF_IN_EN, 32'h0000_000D);
        bus(1'b0, `MSM_OFF_IRQ_STAT, 32'h0);
        $display("test random states done");
        u_fe.burst(1, v, 10'h194, 5'h00);
        rchk(`MSM_OFF_ADC_BASE, 32'h0000_0194);
        chk({31'h0, irq}, 32'h0);
        u_fe.burst(1, v, 10'h2A0, 5'h00);
        rchk(`MSM_OFF_ADC_BASE, 32'h0000_02A0);
        chk({31'h0, irq}, 32'h1);
        bus(1'b0, `MSM_OFF_IRQ_STAT, 32'h0);
        chk(q, stat_word(1'b0, 1'b1, 1'b0));
        $display("test analog done");
        bus(1'b1, `MSM_OFF_POLL_TIME, 32'h0000_0014);
        bus(1'b1, `MSM_OFF_POLL_ACT, 32'h0000_0005);
        bus(1'b1, `MSM_OFF_CONFIG, 32'h0000_0033);
        hi = 0;
        repeat (2000)
        begin
            @(posedge sys_clk_in);
            hi += poll;
        end
        chk({31'h0, hi >= 400 && hi <= 600}, 32'h1);
        $display("test polling done");
        tally_and_finish;
    end
endmodule // multi_switch_input_monitor_test
